// >>> rtl/liv_pkg.sv
// constants for the local interrupt virtual-wire unit
package liv_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam int          VEC_W            = 8;
  localparam int          FETCH_W          = 20;
  localparam int          NUM_PRIO         = 16;
  // register addresses
  localparam logic [7:0]  ADDR_BASE_MSR    = 8'h1B;
  localparam logic [7:0]  ADDR_POWERON_MSR = 8'h2A;
  localparam logic [7:0]  ADDR_LVT0        = 8'h40;
  localparam logic [7:0]  ADDR_LVT1        = 8'h44;
  localparam logic [7:0]  ADDR_STATUS      = 8'h50;
  localparam logic [7:0]  ADDR_LAST_VEC    = 8'h54;
  // field positions and field values
  localparam int          BASE_EN_BIT      = 11;
  localparam int          LOW_POWER_BIT    = 26;
  localparam int          LVT_MASK_BIT     = 16;
  localparam int          LVT_MODE_LSB     = 8;
  localparam int          ST_SPURIOUS_BIT  = 0;
  localparam int          ST_WAIT_BIT      = 1;
  localparam int          ST_EXT_BUSY_BIT  = 2;
  localparam int          ST_SERIAL_LSB    = 16;
  localparam logic [2:0]  MODE_EXT_CTRL    = 3'h7;
  localparam int          START_SHIFT      = 12;
  // reset values and LVT write mask
  localparam logic [31:0] BASE_MSR_RESET   = 32'h0000_0800;
  localparam logic [31:0] POWERON_RESET    = 32'h0000_0000;
  localparam logic [31:0] LVT_RESET        = 32'h0001_0000;
  localparam logic [31:0] LVT_WR_MASK      = 32'h0001_0700;

  typedef enum logic [0:0] {
    LIV_ACK_IDLE = 1'b0,
    LIV_ACK_EXT  = 1'b1
  } liv_ack_t;

  typedef enum logic [0:0] {
    LIV_CORE_RUN  = 1'b0,
    LIV_CORE_WAIT = 1'b1
  } liv_core_t;
endpackage

// >>> rtl/liv_local_irq_unit.sv
// local interrupt unit: virtual-wire delivery, serial interrupts, wake-up
// Operation
// - an asserted local input set for external-controller delivery leads to an acknowledge cycle that fetches the vector.
// - the acknowledge is still forwarded to the external bus when the input drops before it completes.
// - on a spurious interrupt the vector answered by the legacy controller is delivered, never the reserved 0Fh.
// - a drop and fast reassert at the moment of the core acknowledge still yields a valid vector, never 00h.
// - setting the mask bit of an external-controller entry withdraws a pending interrupt from the core in the next cycle.
// - clearing bit 11 of the base register at address 1Bh blocks local-input and serial interrupts; init and start messages still act.
// - an init message puts the processor in a wait state where it does nothing until a start message.
// - the start message makes the waiting processor fetch from an address derived from the message.
// - with low power bit 26 set the core clock stops while waiting and restarts on the start message.
// - after a serial interrupt is accepted, equal or lower priority ones are held off until its acknowledge.
// - a serial interrupt arriving during a forwarded spurious acknowledge is completed as well as that cycle.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module liv_local_irq_unit (
  // clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_reset,
  // register port
  input  wire logic [liv_pkg::ADDR_W-1:0]    i_reg_addr,
  input  wire logic [liv_pkg::DATA_W-1:0]    i_reg_wdata,
  input  wire logic                          i_reg_write,
  input  wire logic                          i_reg_read,
  output logic      [liv_pkg::DATA_W-1:0]    o_reg_rdata,
  // local interrupt pins
  input  wire logic                          i_local_irq_input_zero,
  input  wire logic                          i_local_irq_input_one,
  // core interrupt handshake
  output logic                               o_core_intr,
  input  wire logic                          i_core_ack,
  output logic                               o_core_vec_valid,
  output logic      [liv_pkg::VEC_W-1:0]     o_core_vector,
  // external acknowledge cycle to the legacy controller
  output logic                               o_ext_ack_req,
  input  wire logic                          i_ext_ack_done,
  input  wire logic [liv_pkg::VEC_W-1:0]     i_ext_vector,
  // serial interrupt bus
  input  wire logic                          i_serial_valid,
  input  wire logic [liv_pkg::VEC_W-1:0]     i_serial_vector,
  output logic                               o_serial_accept,
  // init and start messages
  input  wire logic                          i_init_msg,
  input  wire logic                          i_start_msg,
  input  wire logic [liv_pkg::VEC_W-1:0]     i_start_vector,
  output logic                               o_core_halt,
  output logic                               o_core_clk_en,
  output logic                               o_fetch_start,
  output logic      [liv_pkg::FETCH_W-1:0]   o_fetch_addr
);
  import liv_pkg::*;

  function automatic logic is_ext(input logic [31:0] local_vector_table);
    is_ext = (local_vector_table[LVT_MODE_LSB+:3] == MODE_EXT_CTRL) && !local_vector_table[LVT_MASK_BIT];
  endfunction

  function automatic logic [3:0] top_prio(input logic [NUM_PRIO-1:0] pend);
    top_prio = 4'h0;
    for (int k = 0; k < NUM_PRIO; k++) begin
      if (pend[k]) begin
        top_prio = 4'(k);
      end
    end
  endfunction

  logic [1:0]            irq0_sync_q;
  logic [1:0]            irq1_sync_q;
  logic [31:0]           base_q;
  logic [31:0]           poweron_q;
  logic [31:0]           lvt0_q;
  logic [31:0]           lvt1_q;
  logic                  spurious_q;
  logic [VEC_W-1:0]      last_vec_q;
  liv_ack_t              ack_state_q;
  liv_core_t             core_state_q;
  logic                  posted_ext_q;
  logic [NUM_PRIO-1:0]   serial_pend_q;
  logic [VEC_W-1:0]      serial_vec_q [NUM_PRIO];
  logic                  unit_en;
  logic                  ext_pending;
  logic                  serial_any;
  logic [3:0]            serial_top;
  logic [3:0]            arrive_prio;
  logic                  serial_take;
  logic                  ack_idle;
  logic                  serve_serial;
  logic                  start_ext;
  logic                  ext_done;
  logic                  spurious_set;
  logic                  spurious_clr;
  logic                  wr_base;
  logic                  wr_poweron;
  logic                  wr_lvt0;
  logic                  wr_lvt1;

  // pins come from outside the clock domain
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq0_sync_q <= 2'h0;
      irq1_sync_q <= 2'h0;
    end else begin
      irq0_sync_q <= {irq0_sync_q[0], i_local_irq_input_zero};
      irq1_sync_q <= {irq1_sync_q[0], i_local_irq_input_one};
    end
  end

  assign wr_base    = i_reg_write && (i_reg_addr == ADDR_BASE_MSR);
  assign wr_poweron = i_reg_write && (i_reg_addr == ADDR_POWERON_MSR);
  assign wr_lvt0    = i_reg_write && (i_reg_addr == ADDR_LVT0);
  assign wr_lvt1    = i_reg_write && (i_reg_addr == ADDR_LVT1);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      base_q    <= BASE_MSR_RESET;
      poweron_q <= POWERON_RESET;
      lvt0_q    <= LVT_RESET;
      lvt1_q    <= LVT_RESET;
    end else begin
      if (wr_base) begin
        base_q <= i_reg_wdata;
      end
      if (wr_poweron) begin
        poweron_q <= i_reg_wdata;
      end
      if (wr_lvt0) begin
        lvt0_q <= i_reg_wdata & LVT_WR_MASK;
      end
      if (wr_lvt1) begin
        lvt1_q <= i_reg_wdata & LVT_WR_MASK;
      end
    end
  end

  assign unit_en = base_q[BASE_EN_BIT];

  // mask bit gates the live request, so a masking write withdraws it next cycle
  assign ext_pending = unit_en && ((irq0_sync_q[1] && is_ext(lvt0_q))
                                || (irq1_sync_q[1] && is_ext(lvt1_q)));

  assign serial_any  = |serial_pend_q;
  assign serial_top  = top_prio(serial_pend_q);
  assign arrive_prio = i_serial_vector[7:4];
  // only strictly higher classes get in while others wait
  assign serial_take = unit_en && i_serial_valid
                    && (!serial_any || (arrive_prio > serial_top));

  assign ack_idle     = (ack_state_q == LIV_ACK_IDLE);
  assign serve_serial = i_core_ack && ack_idle && serial_any && !posted_ext_q;
  // once the core acknowledged an external post, the cycle is committed
  assign start_ext    = i_core_ack && ack_idle && posted_ext_q;
  assign ext_done     = (ack_state_q == LIV_ACK_EXT) && i_ext_ack_done;

  // serial slots are independent of the external cycle in flight
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      serial_pend_q <= '0;
    end else begin
      for (int k = 0; k < NUM_PRIO; k++) begin
        if (serial_take && (arrive_prio == 4'(k))) begin
          serial_pend_q[k] <= 1'b1;
        end else if (serve_serial && (serial_top == 4'(k))) begin
          serial_pend_q[k] <= 1'b0;
        end else if (!unit_en) begin
          serial_pend_q[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (serial_take) begin
      serial_vec_q[arrive_prio] <= i_serial_vector;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_serial_accept <= 1'b0;
    end else begin
      o_serial_accept <= serial_take;
    end
  end

  // acknowledge sequencing
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ack_state_q <= LIV_ACK_IDLE;
    end else begin
      unique case (ack_state_q)
        LIV_ACK_IDLE: begin
          if (start_ext) begin
            ack_state_q <= LIV_ACK_EXT;
          end
        end
        LIV_ACK_EXT: begin
          if (i_ext_ack_done) begin
            ack_state_q <= LIV_ACK_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_ext_ack_req <= 1'b0;
    end else if (start_ext) begin
      o_ext_ack_req <= 1'b1;
    end else if (i_ext_ack_done) begin
      o_ext_ack_req <= 1'b0;
    end
  end

  // what the core sees as posted decides how its acknowledge is served
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      posted_ext_q <= 1'b0;
      o_core_intr  <= 1'b0;
    end else if (ack_idle && !i_core_ack) begin
      posted_ext_q <= ext_pending && !serial_any;
      o_core_intr  <= ext_pending || serial_any;
    end else begin
      posted_ext_q <= posted_ext_q && ack_idle && !i_core_ack;
      o_core_intr  <= 1'b0;
    end
  end

  // vector only ever comes from a controller answer or a stored serial slot
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_core_vec_valid <= 1'b0;
      o_core_vector    <= 8'h00;
    end else if (ext_done) begin
      o_core_vec_valid <= 1'b1;
      o_core_vector    <= i_ext_vector;
    end else if (serve_serial) begin
      o_core_vec_valid <= 1'b1;
      o_core_vector    <= serial_vec_q[serial_top];
    end else begin
      o_core_vec_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      last_vec_q <= 8'h00;
    end else if (ext_done) begin
      last_vec_q <= i_ext_vector;
    end else if (serve_serial) begin
      last_vec_q <= serial_vec_q[serial_top];
    end
  end

  // spurious: request gone at acknowledge or before the external answer
  assign spurious_set = (start_ext && !ext_pending)
                     || ((ack_state_q == LIV_ACK_EXT) && !ext_pending);
  assign spurious_clr = i_reg_write && (i_reg_addr == ADDR_STATUS)
                     && i_reg_wdata[ST_SPURIOUS_BIT];

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      spurious_q <= 1'b0;
    end else if (spurious_set) begin
      spurious_q <= 1'b1;
    end else if (spurious_clr) begin
      spurious_q <= 1'b0;
    end
  end

  // wake-up: init parks the core, start releases it
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      core_state_q <= LIV_CORE_RUN;
    end else begin
      unique case (core_state_q)
        LIV_CORE_RUN: begin
          if (i_init_msg) begin
            core_state_q <= LIV_CORE_WAIT;
          end
        end
        LIV_CORE_WAIT: begin
          if (i_start_msg && !i_init_msg) begin
            core_state_q <= LIV_CORE_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_core_halt   <= 1'b0;
      o_core_clk_en <= 1'b1;
    end else if (i_init_msg) begin
      o_core_halt   <= 1'b1;
      o_core_clk_en <= !poweron_q[LOW_POWER_BIT];
    end else if (i_start_msg && (core_state_q == LIV_CORE_WAIT)) begin
      o_core_halt   <= 1'b0;
      o_core_clk_en <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_fetch_start <= 1'b0;
      o_fetch_addr  <= 20'h0_0000;
    end else if (i_start_msg && !i_init_msg && (core_state_q == LIV_CORE_WAIT)) begin
      o_fetch_start <= 1'b1;
      o_fetch_addr  <= {i_start_vector, 12'h000};
    end else begin
      o_fetch_start <= 1'b0;
    end
  end

  // read data in the cycle after the strobe only
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_read) begin
      unique case (i_reg_addr)
        ADDR_BASE_MSR:    o_reg_rdata <= base_q;
        ADDR_POWERON_MSR: o_reg_rdata <= poweron_q;
        ADDR_LVT0:        o_reg_rdata <= lvt0_q;
        ADDR_LVT1:        o_reg_rdata <= lvt1_q;
        ADDR_STATUS: begin
          o_reg_rdata <= {serial_pend_q, 13'h0000, !ack_idle,
                          (core_state_q == LIV_CORE_WAIT), spurious_q};
        end
        ADDR_LAST_VEC:    o_reg_rdata <= {24'h00_0000, last_vec_q};
        default:          o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/liv_legacy_ctrl_model.sv
// legacy controller model answering forwarded acknowledge cycles
`timescale 1ns/100ps
`default_nettype none
module liv_legacy_ctrl_model (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // acknowledge handshake
  input  wire logic       i_ext_ack_req,
  input  wire logic [3:0] i_delay,
  input  wire logic [7:0] i_vector,
  output logic            o_done,
  output logic      [7:0] o_vector
);
  int cnt;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !i_ext_ack_req || o_done) begin
      cnt    <= 0;
      o_done <= 1'b0;
    end else begin
      cnt    <= cnt + 1;
      o_done <= (cnt >= int'(i_delay));
    end
  end
  // junk outside the answer cycle so a late sample never passes
  assign o_vector = o_done ? i_vector : ~(i_vector ^ cnt[7:0]);
endmodule
`default_nettype wire

// >>> testbench/liv_local_irq_unit_asserts.sv
// port checks for the local interrupt unit
`timescale 1ns/100ps
`default_nettype none
module liv_local_irq_unit_asserts (
  // clock, reset, handshakes
  input wire logic                        i_ref_clk,
  input wire logic                        i_reset,
  input wire logic                        o_core_intr,
  input wire logic                        i_core_ack,
  input wire logic                        o_core_vec_valid,
  input wire logic [liv_pkg::VEC_W-1:0]   o_core_vector,
  input wire logic                        o_ext_ack_req,
  input wire logic                        i_ext_ack_done,
  input wire logic [liv_pkg::VEC_W-1:0]   i_ext_vector,
  input wire logic                        i_serial_valid,
  input wire logic                        o_serial_accept,
  // wake-up
  input wire logic                        i_init_msg,
  input wire logic                        i_start_msg,
  input wire logic [liv_pkg::VEC_W-1:0]   i_start_vector,
  input wire logic                        o_core_halt,
  input wire logic                        o_core_clk_en,
  input wire logic                        o_fetch_start,
  input wire logic [liv_pkg::FETCH_W-1:0] o_fetch_addr
);
  import liv_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_ext_done;
    o_ext_ack_req && i_ext_ack_done;
  endsequence
  sequence s_wake;
    o_core_halt && i_start_msg && !i_init_msg;
  endsequence
  a_ext_after_ack: assert property ($rose(o_ext_ack_req) |-> $past(i_core_ack))
    else $error("ext ack cycle without core ack");
  a_ext_req_held: assert property (o_ext_ack_req && !i_ext_ack_done |=> o_ext_ack_req)
    else $error("ext ack cycle dropped early");
  a_ext_vector_out: assert property (s_ext_done |=> o_core_vec_valid && !o_ext_ack_req
    && o_core_vector == $past(i_ext_vector)) else $error("vector not from controller");
  a_no_intr_busy: assert property (o_ext_ack_req |-> !o_core_intr)
    else $error("post during ext cycle");
  a_init_halts: assert property (i_init_msg |=> o_core_halt)
    else $error("init did not halt");
  a_halt_holds: assert property (o_core_halt && !i_start_msg |=> o_core_halt)
    else $error("halt left without start");
  a_wake_fetch: assert property (s_wake |=> o_fetch_start && !o_core_halt && o_core_clk_en
    && o_fetch_addr == {$past(i_start_vector), 12'h000}) else $error("bad wake");
  a_fetch_cause: assert property (o_fetch_start |-> $past(o_core_halt && i_start_msg))
    else $error("fetch without start");
  a_clk_stop_wait: assert property (!o_core_clk_en |-> o_core_halt)
    else $error("clock stopped while running");
  a_accept_cause: assert property (o_serial_accept |-> $past(i_serial_valid))
    else $error("accept without offer");
endmodule
bind liv_local_irq_unit liv_local_irq_unit_asserts u_chk (.*);
`default_nettype wire

// >>> testbench/test_local_interrupt_virtual_wire.sv
// self-checking bench for the local interrupt unit
`timescale 1ns/100ps
`default_nettype none
module test_local_interrupt_virtual_wire;
  import liv_pkg::*;
  logic        clk, rst, wr, rd_s, pin0, pin1, ack, sv, init, start, en;
  logic        intr, vv, ereq, edone, sacc, halt, cken, fst;
  logic [7:0]  addr, svec, stvec, pvec, cvec, evec;
  logic [31:0] wdata, rdata;
  logic [19:0] faddr;
  logic [3:0]  dly;
  logic [7:0]  q[$];
  int          err_total, tests_run, k;
  int          seed = 75;

  liv_local_irq_unit u_dut (.i_ref_clk(clk), .i_reset(rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd_s), .o_reg_rdata(rdata),
    .i_local_irq_input_zero(pin0), .i_local_irq_input_one(pin1), .o_core_intr(intr),
    .i_core_ack(ack), .o_core_vec_valid(vv), .o_core_vector(cvec), .o_ext_ack_req(ereq),
    .i_ext_ack_done(edone), .i_ext_vector(evec), .i_serial_valid(sv),
    .i_serial_vector(svec), .o_serial_accept(sacc), .i_init_msg(init), .i_start_msg(start),
    .i_start_vector(stvec), .o_core_halt(halt), .o_core_clk_en(cken),
    .o_fetch_start(fst), .o_fetch_addr(faddr));
  liv_legacy_ctrl_model u_ctrl (.i_ref_clk(clk), .i_reset(rst), .i_ext_ack_req(ereq),
    .i_delay(dly), .i_vector(pvec), .o_done(edone), .o_vector(evec));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    tick();
    wr    <= 1'b0;
    // one idle edge so a following write never sets the strobe in this step
    tick();
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    addr <= a;
    rd_s <= 1'b1;
    tick();
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e, "register read");
    tick();
  endtask
  // bounded wait; a timeout ends the run at once
  task automatic wait_hi(ref logic s, input string m);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(negedge clk);
      ok = (s === 1'b1);
    end
    @(posedge clk);
    chk(ok, 1'b1, m);
    if (!ok) end_sim();
  endtask
  task automatic quiet(input string m);
    repeat (8) begin
      @(negedge clk);
      chk(intr, 1'b0, m);
    end
    @(posedge clk);
  endtask
  // a post that dropped before the ack edge ignores the ack, so the core retries
  task automatic serve(input logic [7:0] e);
    logic took;
    took = 1'b0;
    for (int t = 0; t < 8 && !took; t++) begin
      wait_hi(intr, "interrupt posted");
      ack <= 1'b1;
      @(negedge clk);
      took = intr;
      tick();
      ack <= 1'b0;
    end
    wait_hi(vv, "vector valid");
    chk(cvec, e, "core vector");
  endtask
  function automatic logic [7:0] pop_max();
    int b;
    b = 0;
    foreach (q[i]) if (q[i][7:4] > q[b][7:4]) b = i;
    pop_max = q[b];
    q.delete(b);
  endfunction
  // taken only above every pending priority class
  task automatic ser(input logic [7:0] v);
    logic e;
    e = en;
    foreach (q[i]) if (v[7:4] <= q[i][7:4]) e = 1'b0;
    sv   <= 1'b1;
    svec <= v;
    tick();
    sv   <= 1'b0;
    @(negedge clk);
    chk(sacc, e, "serial accept");
    if (e) q.push_back(v);
    tick();
  endtask

  initial begin
    {wr, rd_s, pin0, pin1, ack, sv, init, start} = '0;
    {addr, wdata, svec, stvec} = '0;
    dly = 4'h1;
    en = 1'b1;
    pvec = 8'h20 | 8'($random(seed) & 31);
    rst = 1'b1;
    tick(5);
    rst <= 1'b0;
    rreg(ADDR_BASE_MSR, BASE_MSR_RESET, 32'hFFFF_FFFF);
    rreg(ADDR_POWERON_MSR, POWERON_RESET, 32'hFFFF_FFFF);
    rreg(ADDR_LVT1, LVT_RESET, 32'hFFFF_FFFF);
    wreg(8'h10, 32'hFFFF_FFFF);
    rreg(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
    wreg(ADDR_LVT0, 32'h0000_0700);
    rreg(ADDR_LVT0, 32'h0000_0700, 32'hFFFF_FFFF);
    pin0 <= 1'b1;
    serve(pvec);
    for (k = 1; k < 4; k++) begin
      pin0 <= 1'b0;
      tick(k);
      pin0 <= 1'b1;
      serve(pvec);
    end
    pin0 <= 1'b0;
    tick(6);
    // input withdrawn right at the ack, slow controller, serial arrives meanwhile
    dly  <= 4'h8;
    pin0 <= 1'b1;
    wait_hi(intr, "interrupt posted");
    pin0 <= 1'b0;
    ack  <= 1'b1;
    tick();
    ack  <= 1'b0;
    @(negedge clk);
    chk(ereq, 1'b1, "forwarded ack");
    tick(2);
    ser(8'h90);
    wait_hi(vv, "vector valid");
    chk(cvec, pvec, "spurious vector");
    rreg(ADDR_LAST_VEC, {24'h00_0000, pvec}, 32'hFFFF_FFFF);
    serve(pop_max());
    rreg(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    wreg(ADDR_STATUS, 32'h0000_0001);
    rreg(ADDR_STATUS, 32'h0000_0000, 32'h0000_0001);
    dly <= 4'h1;
    ser(8'h50);
    ser(8'h40);
    ser(8'h50);
    ser(8'h60);
    for (k = 0; k < 4; k++) ser(8'($random(seed)));
    while (q.size() > 0) serve(pop_max());
    pin0 <= 1'b1;
    wait_hi(intr, "interrupt posted");
    wreg(ADDR_LVT0, 32'h0001_0700);
    tick(2);
    pin1 <= 1'b1;
    quiet("masked entry");
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    tick(4);
    wreg(ADDR_LVT0, 32'h0000_0700);
    wreg(ADDR_BASE_MSR, 32'h0000_0000);
    en = 1'b0;
    pin0 <= 1'b1;
    ser(8'h30);
    quiet("unit disabled");
    pin0 <= 1'b0;
    tick(4);
    wreg(ADDR_BASE_MSR, BASE_MSR_RESET);
    en = 1'b1;
    for (k = 0; k < 2; k++) begin
      wreg(ADDR_POWERON_MSR, 32'(k) << LOW_POWER_BIT);
      init <= 1'b1;
      tick();
      init <= 1'b0;
      @(negedge clk);
      chk({halt, cken}, {1'b1, k == 0}, "init wait");
      tick(3);
      stvec <= 8'($random(seed));
      start <= 1'b1;
      tick();
      start <= 1'b0;
      @(negedge clk);
      chk({halt, cken, fst, faddr}, {3'b011, stvec, 12'h000}, "start fetch");
      @(posedge clk);
    end
    start <= 1'b1;
    tick();
    start <= 1'b0;
    @(negedge clk);
    chk({halt, fst}, 2'b00, "start while running");
    end_sim();
  end
endmodule
`default_nettype wire
